// ---- rdts_pkg.sv ----
// Package: register indices, field positions, reset values and codes for the timer section
package rdts_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RUN_CTRL = 8'h0E;
  localparam logic [7:0] IDX_T0_CFG = 8'h0F;
  localparam logic [7:0] IDX_T0_RELOAD_HI = 8'h10;
  localparam logic [7:0] IDX_T0_RELOAD_LO = 8'h11;
  localparam logic [7:0] IDX_T0_COUNT_HI = 8'h12;
  localparam logic [7:0] IDX_T0_COUNT_LO = 8'h13;
  localparam logic [7:0] IDX_T1_CFG = 8'h14;
  localparam logic [7:0] IDX_UF_FLAGS = 8'h20;

  // Config register field positions
  localparam int CFG_HALT_RX_BIT = 7;
  localparam int CFG_MODE_HI = 5;
  localparam int CFG_MODE_LO = 4;
  localparam int CFG_RELOAD_ZERO_BIT = 3;
  localparam int CFG_CLK_HI = 1;
  localparam int CFG_CLK_LO = 0;
  localparam logic [7:0] CFG_WR_MASK = 8'hBB;

  // Run-control layout: enables low nibble, running bits high nibble
  localparam int RUN_ENABLE_LO = 0;
  localparam int RUN_STATE_LO = 4;

  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RELOAD_BYTE_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Start mode codes
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_TX_END = 2'h1;
  localparam logic [1:0] MODE_TRIM_SAT = 2'h2;
  localparam logic [1:0] MODE_TRIM_UF = 2'h3;

  // Count clock select codes
  localparam logic [1:0] CLK_FAST = 2'h0;
  localparam logic [1:0] CLK_SLOW = 2'h1;
  localparam logic [1:0] CLK_CHAIN_A = 2'h2;
  localparam logic [1:0] CLK_CHAIN_B = 2'h3;

  // Chain sources per timer for select codes 10b and 11b
  localparam logic [1:0] CHAIN_A_SRC [4] = '{2'h2, 2'h0, 2'h0, 2'h0};
  localparam logic [1:0] CHAIN_B_SRC [4] = '{2'h1, 2'h2, 2'h1, 2'h2};

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rdts_testbench.sv ----
// Self-checking bench for the timer section register slave and counters
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk;
  logic aresetn;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  // Event inputs: 0 fast tick, 1 slow tick, 2 tx end, 3 rx bits, 4 oscillator pin
  logic [4:0] ev;
  logic [3:0] act;
  logic [3:0] flg;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [3:0] strb;
  int num_errors;
  int samples_checked;

  logic [11:0] row_a [9] = '{12'h03C, 12'h03C, 12'h050, 12'h050, 12'h040, 12'h044,
    12'h04C, 12'h038, 12'h004};
  logic [7:0] row_w [9] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'hA5, 8'h5A, 8'hFF, 8'hF0, 8'h12};
  logic [7:0] row_r [9] = '{8'hBB, 8'h00, 8'hBB, 8'h00, 8'hA5, 8'h5A, 8'h00, 8'h00, 8'h00};
  logic [1:0] row_s [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

  // Small reload for the other timers keeps chained runs short
  rdts_timer_section #(.AW(12), .OTHER_RELOAD(16'h0002), .UPPER_TIMER_CFG(8'h00)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tick_fast(ev[0]), .tick_slow(ev[1]), .tx_end(ev[2]),
    .rx_bits(ev[3]), .lfo_pin(ev[4]), .timer_active(act),
    .underflow_interrupt_flag_q(flg)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    num_errors++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 50) hang();
    end
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) hang();
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdreg(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) hang();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) hang();
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    rdreg(a);
    chk(rd, {24'h0, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Strobe held n cycles, then time for synchronisers and chained lag
  task automatic pulse(input int i, input int n);
    ev[i] <= 1'b1;
    idle(n);
    ev[i] <= 1'b0;
    idle(4);
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    ev = '0;
    strb = 4'hF;
    num_errors = 0;
    samples_checked = 0;
    idle(16);
    aresetn <= 1'b1;
    idle(2);
    chk(act, 4'h0);
    for (int i = 0; i < 7; i++) begin
      rdchk(12'h038 + 12'(4 * i), 8'h00);
    end
    rdchk(12'h080, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 9; i++) begin
      wr(row_a[i], row_w[i]);
      chk(rsp, row_s[i]);
      rdreg(row_a[i]);
      chk(rd, {24'h0, row_r[i]});
      chk(rsp, row_s[i]);
    end
    // Lane 0 strobe low: accepted but nothing stored
    strb <= 4'h0;
    wr(12'h040, 8'h77);
    strb <= 4'hF;
    chk(rsp, 2'h0);
    rdchk(12'h040, 8'hA5);
    $display("register table done");
    wr(12'h03C, 8'h00);
    wr(12'h040, 8'h00);
    wr(12'h044, 8'h03);
    wr(12'h038, 8'h11);
    idle(2);
    chk(act, 4'h1);
    pulse(0, 1);
    pulse(0, 1);
    rdchk(12'h04C, 8'h01);
    wr(12'h044, 8'h09);
    rdchk(12'h04C, 8'h01);
    pulse(0, 1);
    pulse(0, 1);
    chk(act, 4'h0);
    rdchk(12'h080, 8'h01);
    wr(12'h080, 8'h0F);
    rdchk(12'h080, 8'h00);
    wr(12'h040, 8'h02);
    wr(12'h038, 8'h11);
    idle(2);
    rdchk(12'h048, 8'h02);
    rdchk(12'h04C, 8'h09);
    wr(12'h038, 8'h01);
    idle(2);
    chk(act, 4'h0);
    pulse(0, 1);
    rdchk(12'h04C, 8'h09);
    $display("count and reload done");
    wr(12'h03C, 8'h01);
    wr(12'h038, 8'h11);
    idle(2);
    pulse(0, 1);
    rdchk(12'h04C, 8'h09);
    pulse(1, 1);
    rdchk(12'h04C, 8'h08);
    wr(12'h038, 8'h01);
    $display("clock select done");
    wr(12'h03C, 8'h80);
    wr(12'h038, 8'h11);
    idle(2);
    pulse(3, 1);
    chk(act, 4'h0);
    wr(12'h03C, 8'hB0);
    wr(12'h038, 8'h11);
    idle(2);
    pulse(3, 1);
    chk(act, 4'h1);
    pulse(4, 4);
    chk(act, 4'h0);
    pulse(4, 4);
    chk(act, 4'h1);
    rdchk(12'h04C, 8'h09);
    wr(12'h038, 8'h01);
    wr(12'h03C, 8'h10);
    pulse(2, 1);
    chk(act, 4'h1);
    wr(12'h038, 8'h01);
    wr(12'h03C, 8'h00);
    pulse(2, 1);
    chk(act, 4'h0);
    wr(12'h038, 8'h11);
    pulse(3, 1);
    chk(act, 4'h1);
    wr(12'h038, 8'h01);
    $display("start modes done");
    wr(12'h03C, 8'h02);
    wr(12'h040, 8'h00);
    wr(12'h044, 8'h05);
    wr(12'h038, 8'h55);
    idle(2);
    repeat (3) pulse(0, 1);
    chk(act, 4'h1);
    rdchk(12'h04C, 8'h04);
    rdchk(12'h080, 8'h04);
    wr(12'h080, 8'h0F);
    wr(12'h038, 8'h01);
    wr(12'h03C, 8'h08);
    wr(12'h044, 8'h01);
    wr(12'h050, 8'h02);
    wr(12'h038, 8'h33);
    idle(2);
    repeat (4) pulse(0, 1);
    rdchk(12'h080, 8'h01);
    chk(act, 4'h3);
    repeat (2) pulse(0, 1);
    chk(act, 4'h1);
    rdchk(12'h080, 8'h03);
    chk(flg, 4'h3);
    $display("chaining done");
    // Saturating trim mode: counter parks at zero, no underflow
    wr(12'h080, 8'h0F);
    wr(12'h03C, 8'h20);
    wr(12'h038, 8'h11);
    repeat (2) pulse(0, 1);
    chk(act, 4'h1);
    rdchk(12'h04C, 8'h00);
    rdchk(12'h080, 8'h00);
    chk(flg, 4'h0);
    $display("saturating trim done");
    end_sim();
  end
endmodule

// ---- rdts_timer_section.sv ----
// Timer section: four down-counters, masked run control and AXI4-Lite register slave
// Behaviour
// [R1] Masked write changes only enabled running bits
// [R2] Upper nibble shows running; write starts/stops
// [R3] Lower nibble write-only enables, read zero
// [R4] Halt-on-receive stops timer after four bits
// [R5] Halt-on-receive ignored in trimming modes
// [R6] Mode 00 manual, 01 starts after transmit
// [R7] Modes 10/11 trim oscillator on rising edges
// [R8] Reload-on-zero reloads and keeps counting; mode 10 holds the counter at zero with no reload
// [R9] Otherwise stop at zero, clear running; mode 10 holds at zero with running left set
// [R10] Every underflow sets the sticky flag
// [R11] Select 00 fast clock, 01 slow clock
// [R12] Timer zero chains on timer two/one underflows
// [R13] Start loads counter from high:low reload
// [R14] Reload writes wait for next start
// [R15] Software avoids count reads during reception
// [R16] Timer one config mirrors timer zero layout
// [R17] Timer one chains on timer zero/two
// [R18] Running counter decrements per selected tick
//
// The AXI4-Lite slave port was left to the implementer.

module rdts_timer_unit #(
  parameter int CW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic [7:0] cfg,
  input wire logic [CW-1:0] reload,
  input wire logic tick_fast,
  input wire logic tick_slow,
  input wire logic chain_a,
  input wire logic chain_b,
  input wire logic rx_bits,
  input wire logic tx_end,
  input wire logic lfo_rise,
  output logic running_q,
  output logic [CW-1:0] count_q,
  output logic underflow_q
);
  logic [1:0] mode;
  logic trim;
  logic tick;
  logic at_zero;
  logic auto_start;
  logic start;
  logic trim_stop;
  logic rx_stop;
  logic uf;

  assign mode = cfg[rdts_pkg::CFG_MODE_HI:rdts_pkg::CFG_MODE_LO];
  assign trim = mode[1]; // R7

  always_comb begin
    unique case (cfg[rdts_pkg::CFG_CLK_HI:rdts_pkg::CFG_CLK_LO]) // R11 R12 R17
      rdts_pkg::CLK_FAST: tick = tick_fast;
      rdts_pkg::CLK_SLOW: tick = tick_slow;
      rdts_pkg::CLK_CHAIN_A: tick = chain_a;
      rdts_pkg::CLK_CHAIN_B: tick = chain_b;
    endcase
  end

  assign at_zero = (count_q == '0);
  // R6 R7
  assign auto_start = !running_q && ((mode == rdts_pkg::MODE_TX_END && tx_end)
    || (trim && lfo_rise));
  assign start = sw_start || auto_start;
  assign trim_stop = running_q && trim && lfo_rise; // R7
  assign rx_stop = running_q && cfg[rdts_pkg::CFG_HALT_RX_BIT] && !trim && rx_bits; // R4 R5
  // Saturating trim mode holds at zero and raises no underflow
  assign uf = running_q && tick && at_zero && (mode != rdts_pkg::MODE_TRIM_SAT); // R7 R10

  // Explicit software control outranks every hardware event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_q <= 1'b0;
    end else if (sw_stop) begin
      running_q <= 1'b0; // R2
    end else if (start) begin
      running_q <= 1'b1; // R2 R6
    end else if (trim_stop || rx_stop) begin
      running_q <= 1'b0; // R4 R7
    end else if (uf && !cfg[rdts_pkg::CFG_RELOAD_ZERO_BIT]) begin
      running_q <= 1'b0; // R9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= CW'(rdts_pkg::COUNT_RST);
    end else if (start) begin
      count_q <= reload; // R13 R14
    end else if (uf && cfg[rdts_pkg::CFG_RELOAD_ZERO_BIT]) begin
      count_q <= reload; // R8
    end else if (running_q && tick && !at_zero) begin
      count_q <= count_q - CW'(1); // R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underflow_q <= 1'b0;
    end else begin
      underflow_q <= uf; // R10
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sw_start;
    sw_start && !sw_stop;
  endsequence

  property p_start_loads;
    s_sw_start |=> running_q && count_q == $past(reload);
  endproperty
  a_start_loads: assert property (p_start_loads) else $error("start did not load reload"); // R13

  property p_stop;
    sw_stop |=> !running_q;
  endproperty
  a_stop: assert property (p_stop) else $error("software stop ignored"); // R2

  property p_rx_halt;
    running_q && cfg[7] && !trim && rx_bits && !sw_start |=> !running_q;
  endproperty
  a_rx_halt: assert property (p_rx_halt) else $error("receive did not halt timer"); // R4

  property p_rx_ignored_trim;
    running_q && trim && rx_bits && !lfo_rise && !sw_stop && !uf |=> running_q;
  endproperty
  a_rx_ignored_trim: assert property (p_rx_ignored_trim) else $error("receive halted trim"); // R5

  property p_manual_stays;
    !running_q && mode == rdts_pkg::MODE_MANUAL && !sw_start |=> !running_q;
  endproperty
  a_manual_stays: assert property (p_manual_stays) else $error("manual mode self-started"); // R6

  property p_restart;
    uf && cfg[3] && !start && !sw_stop |=> running_q && count_q == $past(reload) && underflow_q;
  endproperty
  a_restart: assert property (p_restart) else $error("auto-restart failed"); // R8

  property p_one_shot;
    uf && !cfg[3] && !start && !sw_stop |=> !running_q ##1 (!running_q || $past(start));
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot did not stop"); // R9

  property p_decrement;
    running_q && tick && !at_zero && !start |=> count_q == $past(count_q) - CW'(1);
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not decrement"); // R18

  property p_hold;
    !running_q && !start |=> count_q == $past(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved"); // R14
endmodule

module rdts_timer_section #(
  parameter int AW = 12,
  parameter logic [15:0] OTHER_RELOAD = 16'h00FF,
  parameter logic [7:0] UPPER_TIMER_CFG = 8'h00
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tick_fast,
  input wire logic tick_slow,
  input wire logic tx_end,
  input wire logic rx_bits,
  input wire logic lfo_pin,
  output logic [3:0] timer_active,
  output logic [3:0] underflow_interrupt_flag_q
);
  logic aw_hs, w_hs, b_hs, ar_hs, r_hs;
  logic aw_held_q, w_held_q, aw_held_d, w_held_d, rvalid_d, wr_fire;
  logic [AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_strb0_q;
  logic [7:0] wr_idx, rd_idx;
  logic wr_in_page, rd_in_page, wr_hit, wr_en;
  logic [7:0] zeroth_timer_config_q, first_timer_config_q;
  logic [7:0] reload_upper_byte_q, reload_lower_byte_q;
  logic [3:0] sw_start, sw_stop, active, uf;
  logic [15:0] zeroth_count;
  logic [7:0] rd_val;
  logic rd_hit;
  logic lfo_meta_q, lfo_sync_q, lfo_prev_q;
  logic lfo_rise;
  logic wr_run;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign b_hs = s_axi_bvalid && s_axi_bready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign r_hs = s_axi_rvalid && s_axi_rready;
  assign aw_held_d = (aw_held_q || aw_hs) && !b_hs;
  assign w_held_d = (w_held_q || w_hs) && !b_hs;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rvalid_d = (s_axi_rvalid && !s_axi_rready) || ar_hs;

  assign wr_idx = aw_addr_q[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_in_page = (aw_addr_q[AW-1:10] == '0) && (aw_addr_q[1:0] == 2'h0);
  assign rd_in_page = (s_axi_araddr[AW-1:10] == '0) && (s_axi_araddr[1:0] == 2'h0);
  assign wr_hit = wr_in_page && (wr_idx inside {rdts_pkg::IDX_RUN_CTRL, rdts_pkg::IDX_T0_CFG,
    rdts_pkg::IDX_T0_RELOAD_HI, rdts_pkg::IDX_T0_RELOAD_LO, rdts_pkg::IDX_T0_COUNT_HI,
    rdts_pkg::IDX_T0_COUNT_LO, rdts_pkg::IDX_T1_CFG, rdts_pkg::IDX_UF_FLAGS});
  assign wr_en = wr_fire && wr_hit && w_strb0_q;
  assign wr_run = wr_en && wr_idx == rdts_pkg::IDX_RUN_CTRL;

  // Write channel: address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      s_axi_awready <= !aw_held_d;
      s_axi_wready <= !w_held_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rdts_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? rdts_pkg::RESP_OKAY : rdts_pkg::RESP_SLVERR;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Config and reload storage; reserved bits never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zeroth_timer_config_q <= rdts_pkg::CFG_RST;
      first_timer_config_q <= rdts_pkg::CFG_RST;
      reload_upper_byte_q <= rdts_pkg::RELOAD_BYTE_RST;
      reload_lower_byte_q <= rdts_pkg::RELOAD_BYTE_RST;
    end else if (wr_en) begin
      unique case (wr_idx)
        rdts_pkg::IDX_T0_CFG: zeroth_timer_config_q <= w_data_q[7:0] & rdts_pkg::CFG_WR_MASK;
        rdts_pkg::IDX_T1_CFG: first_timer_config_q <= w_data_q[7:0] & rdts_pkg::CFG_WR_MASK; // R16
        rdts_pkg::IDX_T0_RELOAD_HI: reload_upper_byte_q <= w_data_q[7:0]; // R14
        rdts_pkg::IDX_T0_RELOAD_LO: reload_lower_byte_q <= w_data_q[7:0]; // R14
        default: ;
      endcase
    end
  end

  function automatic int RUN_EN(input int i);
    return rdts_pkg::RUN_ENABLE_LO + i;
  endfunction

  function automatic int RUN_ST(input int i);
    return rdts_pkg::RUN_STATE_LO + i;
  endfunction

  // Masked run control: enable bit i gates running bit i+4
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sw_start[i] = wr_run && w_data_q[RUN_EN(i)] && w_data_q[RUN_ST(i)]; // R1 R2
      sw_stop[i] = wr_run && w_data_q[RUN_EN(i)] && !w_data_q[RUN_ST(i)]; // R1 R2
    end
  end

  // Oscillator pin crosses in through two flops before edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfo_meta_q <= 1'b0;
      lfo_sync_q <= 1'b0;
      lfo_prev_q <= 1'b0;
    end else begin
      lfo_meta_q <= lfo_pin;
      lfo_sync_q <= lfo_meta_q;
      lfo_prev_q <= lfo_sync_q;
    end
  end
  assign lfo_rise = lfo_sync_q && !lfo_prev_q; // R7

  // Chained ticks use registered underflows, so no combinational loop
  for (genvar g = 0; g < 4; g++) begin : g_timer
    logic [7:0] cfg;
    logic [15:0] reload;
    logic [15:0] count;
    assign cfg = (g == 0) ? zeroth_timer_config_q :
      (g == 1) ? first_timer_config_q : UPPER_TIMER_CFG;
    assign reload = (g == 0) ? {reload_upper_byte_q, reload_lower_byte_q} : OTHER_RELOAD; // R13
    rdts_timer_unit #(.CW(16)) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .sw_start(sw_start[g]),
      .sw_stop(sw_stop[g]),
      .cfg(cfg),
      .reload(reload),
      .tick_fast(tick_fast),
      .tick_slow(tick_slow),
      .chain_a(uf[rdts_pkg::CHAIN_A_SRC[g]]), // R12 R17
      .chain_b(uf[rdts_pkg::CHAIN_B_SRC[g]]), // R12 R17
      .rx_bits(rx_bits),
      .tx_end(tx_end),
      .lfo_rise(lfo_rise),
      .running_q(active[g]),
      .count_q(count),
      .underflow_q(uf[g])
    );
  end
  assign zeroth_count = g_timer[0].count;
  assign timer_active = active;

  // Sticky flags: an underflow in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underflow_interrupt_flag_q <= rdts_pkg::FLAGS_RST;
    end else begin
      underflow_interrupt_flag_q <= (underflow_interrupt_flag_q
        & ~((wr_en && wr_idx == rdts_pkg::IDX_UF_FLAGS) ? w_data_q[3:0] : 4'h0)) | uf; // R10
    end
  end

  // Live count is read unlatched; a read mid-reception may tear the two bytes
  always_comb begin
    rd_val = 8'h00;
    rd_hit = rd_in_page;
    unique case (rd_idx)
      rdts_pkg::IDX_RUN_CTRL: rd_val = {active, 4'h0}; // R2 R3
      rdts_pkg::IDX_T0_CFG: rd_val = zeroth_timer_config_q;
      rdts_pkg::IDX_T0_RELOAD_HI: rd_val = reload_upper_byte_q;
      rdts_pkg::IDX_T0_RELOAD_LO: rd_val = reload_lower_byte_q;
      rdts_pkg::IDX_T0_COUNT_HI: rd_val = zeroth_count[15:8]; // R15
      rdts_pkg::IDX_T0_COUNT_LO: rd_val = zeroth_count[7:0]; // R15
      rdts_pkg::IDX_T1_CFG: rd_val = first_timer_config_q; // R16
      rdts_pkg::IDX_UF_FLAGS: rd_val = {4'h0, underflow_interrupt_flag_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rdts_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_hs) begin
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_hit ? rdts_pkg::RESP_OKAY : rdts_pkg::RESP_SLVERR;
      end
    end
  end

  default clocking cbt @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_flag_set;
    uf[0] |=> underflow_interrupt_flag_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("underflow flag not set"); // R10

  property p_enables_read_zero;
    ar_hs && rd_idx == rdts_pkg::IDX_RUN_CTRL |=> s_axi_rdata[3:0] == 4'h0;
  endproperty
  a_enables_read_zero: assert property (p_enables_read_zero) else $error("enable bits read"); // R3

  property p_masked_keep;
    wr_run && !w_data_q[0] && !active[0] && !tx_end && !lfo_rise |=> !active[0];
  endproperty
  a_masked_keep: assert property (p_masked_keep) else $error("unmasked bit changed"); // R1
endmodule
